/* File: gimh_handler.sv */
// Interface message handler: remote/local, lockout, addressing, clears, trigger
`include "gimh_params.svh"

// Notes on behaviour
// RULE1 - Remote enable alone does not go remote; listen addressing with enable does.
// RULE2 - Talking works in both remote and local states.
// RULE3 - In remote, front panel ignored except power and local key; local key returns local.
// RULE4 - Interface clear forces local, talker idle and listener idle.
// RULE5 - Interface clear leaves configuration, data and event registers alone.
// RULE6 - Controller holds interface clear at least 100 us.
// RULE7 - Local lockout disables all keys including the local key.
// RULE8 - Go-to-local leaves remote and re-enables keys, even under lockout.
// RULE9 - Universal device clear acts without addressing.
// RULE10 - Device clear empties input, output, deferred and blocking commands.
// RULE11 - Device clear leaves configuration and stored data alone.
// RULE12 - Selective device clear acts only while addressed as listener.
// RULE13 - Group trigger counts only for layers whose source is the bus.
// RULE14 - Controller sends untalk, unlisten, listen address, then group trigger.
// RULE15 - Two command languages: standard and legacy.
// RULE16 - Language change resets to power-on defaults; same selection does not.
// RULE17 - Default primary address is 27.
// RULE18 - Controller addresses device to talk to read query answers.
// RULE19 - Talker leaves active on untalk, listen addressing, or interface clear.
// RULE20 - Listener leaves active on unlisten, talk addressing, or interface clear.
// RULE21 - State flags reset to local, unlocked and idle.
module gimh_handler #(
  parameter logic [4:0] DEF_ADDR = `GIMH_DEF_ADDR,
  parameter int IFC_MIN_CYC = `GIMH_IFC_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ren_pin,
  input wire logic ifc_pin,
  input wire logic cmd_valid,
  input wire logic atn,
  input wire logic [6:0] cmd_byte,
  input wire logic [4:0] addr_set,
  input wire logic addr_set_valid,
  input wire logic local_key,
  input wire logic [2:0] bus_trig_src,
  input wire logic lang_sel_valid,
  input wire gimh_pkg::gimh_lang_t lang_sel,
  output gimh_pkg::gimh_state_t state_q,
  output gimh_pkg::gimh_ctrl_t ctrl_q,
  output gimh_pkg::gimh_lang_t lang_q,
  output logic [4:0] addr_q
);
  logic [1:0] ren_sync_q;
  logic [1:0] ifc_sync_q;
  gimh_pkg::gimh_state_t state_d;
  gimh_pkg::gimh_ctrl_t ctrl_d;

  // Pin synchronisers; only second stage is read
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ren_sync_q <= 2'h0;
      ifc_sync_q <= 2'h0;
    end else begin
      ren_sync_q <= {ren_sync_q[0], ren_pin};
      ifc_sync_q <= {ifc_sync_q[0], ifc_pin};
    end
  end

  wire ren = ren_sync_q[1];
  wire ifc = ifc_sync_q[1];
  wire cmd = cmd_valid && atn;
  wire is_mla = cmd && cmd_byte[6:5] == `GIMH_LAG_BASE && cmd_byte[4:0] == addr_q;
  wire is_mta = cmd && cmd_byte[6:5] == `GIMH_TAG_BASE && cmd_byte[4:0] == addr_q;
  wire is_unl = cmd && cmd_byte == `GIMH_CMD_UNL;
  wire is_unt = cmd && cmd_byte == `GIMH_CMD_UNT;
  wire is_oth_ta = cmd && cmd_byte[6:5] == `GIMH_TAG_BASE && !is_mta && !is_unt;
  wire is_llo = cmd && cmd_byte == `GIMH_CMD_LLO;
  wire is_dcl = cmd && cmd_byte == `GIMH_CMD_DCL;
  wire is_gtl = cmd && cmd_byte == `GIMH_CMD_GTL && state_q.listener;
  wire is_sdc = cmd && cmd_byte == `GIMH_CMD_SDC && state_q.listener; // see RULE12
  wire is_get = cmd && cmd_byte == `GIMH_CMD_GET && state_q.listener;
  wire lang_chg = lang_sel_valid && lang_sel != lang_q; // see RULE16
  wire key_ok = !state_q.lockout;

  // Next state of the remote, lockout and addressing flags
  always_comb begin
    state_d = state_q;
    if (is_mla) begin
      state_d.listener = 1'b1;
      state_d.talker = 1'b0; // see RULE19
      if (ren) begin
        state_d.remote = 1'b1; // see RULE1
      end
    end
    if (is_unl || is_mta) begin
      state_d.listener = 1'b0; // see RULE20
    end
    if (is_mta) begin
      state_d.talker = 1'b1; // see RULE2
    end
    if (is_unt || is_oth_ta) begin
      state_d.talker = 1'b0; // see RULE19
    end
    if (is_llo) begin
      state_d.lockout = 1'b1; // see RULE7
    end
    if (local_key && key_ok && state_q.remote && !is_mla) begin
      state_d.remote = 1'b0; // see RULE3
    end
    if (is_gtl) begin
      state_d.remote = 1'b0; // see RULE8
      state_d.lockout = 1'b0;
    end
    if (!ren) begin
      state_d.remote = 1'b0;
      state_d.lockout = 1'b0;
    end
    if (ifc) begin
      state_d.remote = 1'b0; // see RULE4
      state_d.talker = 1'b0;
      state_d.listener = 1'b0;
    end
  end

  // Clear, trigger and panel controls; configuration never touched here (see RULE5, RULE11)
  always_comb begin
    ctrl_d.clear_pulse = is_dcl || is_sdc; // see RULE9
    ctrl_d.trig_pulse = is_get && |bus_trig_src;
    ctrl_d.trig_layer = is_get ? bus_trig_src : 3'h0; // see RULE13
    ctrl_d.lang_reset = lang_chg;
    ctrl_d.panel_enable = lang_chg || (!state_d.remote && !state_d.lockout); // see RULE3
    ctrl_d.local_key_enable = lang_chg || !state_d.lockout; // see RULE7
  end

  // Flag registers, cleared by reset and by a language change
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= '0; // see RULE21
    end else if (lang_chg) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Control outputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= '{default: 1'b0, panel_enable: 1'b1, local_key_enable: 1'b1};
    end else begin
      ctrl_q <= ctrl_d; // see RULE10
    end
  end

  // Language and address selection
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lang_q <= gimh_pkg::gimh_lang_std_t_val; // see RULE15
      addr_q <= DEF_ADDR; // see RULE17
    end else begin
      if (lang_sel_valid) begin
        lang_q <= lang_sel;
      end
      if (addr_set_valid) begin
        addr_q <= addr_set;
      end
    end
  end

  // Remote only after listen addressing with enable
  a_remote_needs_mla: assert property (@(posedge ref_clk) disable iff (reset) // see RULE1
    $rose(state_q.remote) |-> $past(is_mla) && $past(ren))
    else $error("remote entered without listen address");
  // Interface clear forces local and idles talker and listener
  a_ifc_idles: assert property (@(posedge ref_clk) disable iff (reset) // see RULE4
    ifc && !lang_chg |=> !state_q.remote && !state_q.talker && !state_q.listener)
    else $error("interface clear did not idle");
  // Lockout blocks local key
  a_lockout_key: assert property (@(posedge ref_clk) disable iff (reset) // see RULE7
    state_q.lockout && state_q.remote && local_key && ren && !is_gtl && !ifc && !lang_chg
    |=> state_q.remote)
    else $error("local key acted under lockout");
  // Go to local
  a_gtl_local: assert property (@(posedge ref_clk) disable iff (reset) // see RULE8
    is_gtl |=> !state_q.remote && !state_q.lockout ##1 ctrl_q.local_key_enable)
    else $error("go to local failed");
  // Universal clear
  a_dcl_clear: assert property (@(posedge ref_clk) disable iff (reset) // see RULE9
    is_dcl |=> ctrl_q.clear_pulse)
    else $error("device clear missed");
  // Selective clear needs listener
  a_sdc_listen: assert property (@(posedge ref_clk) disable iff (reset) // see RULE12
    ctrl_q.clear_pulse |-> $past(is_dcl) || $past(state_q.listener))
    else $error("selective clear while not listener");
  // Trigger only from bus source
  a_get_source: assert property (@(posedge ref_clk) disable iff (reset) // see RULE13
    ctrl_q.trig_pulse |-> (ctrl_q.trig_layer == $past(bus_trig_src)) && |ctrl_q.trig_layer)
    else $error("trigger without bus source");
  // Talker drops on untalk
  a_unt_idle: assert property (@(posedge ref_clk) disable iff (reset) // see RULE19
    is_unt |=> !state_q.talker)
    else $error("talker stayed active");
  // Listener drops on talk addressing
  a_mta_unlisten: assert property (@(posedge ref_clk) disable iff (reset) // see RULE20
    is_mta |=> !state_q.listener && (state_q.talker || $past(lang_chg) || $past(ifc)))
    else $error("listener stayed active");
  // Same language keeps state
  a_lang_keep: assert property (@(posedge ref_clk) disable iff (reset) // see RULE16
    lang_sel_valid && lang_sel == lang_q |=> !ctrl_q.lang_reset)
    else $error("reset on unchanged language");
  // Front panel held off while remote or locked out
  a_remote_panel: assert property (@(posedge ref_clk) disable iff (reset) // see RULE3
    state_q.remote || state_q.lockout |-> !ctrl_q.panel_enable)
    else $error("panel enabled in remote or lockout");
  // Local key held off under lockout
  a_lockout_keys: assert property (@(posedge ref_clk) disable iff (reset) // see RULE7
    state_q.lockout |-> !ctrl_q.local_key_enable)
    else $error("local key enabled under lockout");
  // Selective clear acts when addressed
  a_sdc_clear: assert property (@(posedge ref_clk) disable iff (reset) // see RULE10
    is_sdc |=> ctrl_q.clear_pulse)
    else $error("selective clear missed");
  // No trigger when no layer takes the bus source
  a_get_no_source: assert property (@(posedge ref_clk) disable iff (reset) // see RULE13
    is_get && bus_trig_src == 3'h0 |=> !ctrl_q.trig_pulse)
    else $error("trigger with no bus source selected");
  // Language change returns flags to defaults
  a_lang_reset: assert property (@(posedge ref_clk) disable iff (reset) // see RULE16
    lang_chg |=> ctrl_q.lang_reset && !(|state_q))
    else $error("language change did not reset");
endmodule

/* File: gimh_params.svh */
// Constants for the bus interface message handler
`ifndef GIMH_PARAMS_SVH
`define GIMH_PARAMS_SVH
`define GIMH_DEF_ADDR 5'h1b
`define GIMH_IFC_MIN_US 100
`define GIMH_CLK_MHZ 100
`define GIMH_IFC_MIN_CYC ((`GIMH_IFC_MIN_US * `GIMH_CLK_MHZ))
`define GIMH_CMD_UNL 7'h3f
`define GIMH_CMD_UNT 7'h5f
`define GIMH_CMD_GTL 7'h01
`define GIMH_CMD_SDC 7'h04
`define GIMH_CMD_GET 7'h08
`define GIMH_CMD_LLO 7'h11
`define GIMH_CMD_DCL 7'h14
`define GIMH_LAG_BASE 2'h1
`define GIMH_TAG_BASE 2'h2
`define GIMH_LAYERS 3
`endif

/* File: gimh_pkg.sv */
// Types for the bus interface message handler
package gimh_pkg;
  typedef enum logic [0:0] {
    gimh_lang_std_t_val = 1'b0,
    gimh_lang_legacy_t_val = 1'b1
  } gimh_lang_t;
  typedef struct packed {
    logic remote;
    logic lockout;
    logic talker;
    logic listener;
  } gimh_state_t;
  typedef struct packed {
    logic clear_pulse;
    logic trig_pulse;
    logic [2:0] trig_layer;
    logic lang_reset;
    logic panel_enable;
    logic local_key_enable;
  } gimh_ctrl_t;
endpackage

/* File: gimh_ctrl_model.sv */
// Bus controller model driving remote enable, interface clear and command bytes
`include "gimh_params.svh"
module gimh_ctrl_model #(
  parameter int IFC_HOLD = `GIMH_IFC_MIN_CYC
) (
  input wire logic ref_clk,
  output logic ren_pin,
  output logic ifc_pin,
  output logic cmd_valid,
  output logic atn,
  output logic [6:0] cmd_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quiet bus at time zero
  initial begin
    ren_pin = 1'b0;
    ifc_pin = 1'b0;
    cmd_valid = 1'b0;
    atn = 1'b0;
    cmd_byte = 7'h00;
  end
  // One command byte for one cycle; released data lines show the inverse
  task automatic send(input logic [6:0] b);
    @(negedge ref_clk);
    cmd_byte = b;
    cmd_valid = 1'b1;
    atn = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    atn = 1'b0;
    cmd_byte = ~b;
    repeat (2) @(negedge ref_clk);
  endtask
  // Interface clear held for the minimum pulse length
  task automatic clear_bus();
    @(negedge ref_clk);
    ifc_pin = 1'b1;
    repeat (IFC_HOLD) @(negedge ref_clk);
    ifc_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
  // Remote enable level, then wait out the synchroniser
  task automatic set_ren(input logic v);
    @(negedge ref_clk);
    ren_pin = v;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

/* File: gimh_handler_tb.sv */
// Self-checking bench for the interface message handler
`include "gimh_params.svh"
module gimh_handler_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic ren; logic [6:0] b; logic [3:0] exp; logic [3:0] mask;} gimh_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ren_pin, ifc_pin, cmd_valid, atn;
  logic [6:0] cmd_byte;
  logic local_key = 1'b0;
  logic [4:0] addr_set = 5'h00;
  logic addr_set_valid = 1'b0;
  logic [2:0] bus_trig_src = 3'h0;
  logic lang_sel_valid = 1'b0;
  gimh_pkg::gimh_lang_t lang_sel = gimh_pkg::gimh_lang_std_t_val;
  gimh_pkg::gimh_state_t state_q;
  gimh_pkg::gimh_ctrl_t ctrl_q;
  gimh_pkg::gimh_lang_t lang_q;
  logic [4:0] addr_q;
  logic [2:0] layers = 3'h0;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_clr = 0;
  int n_lrst = 0;
  gimh_row_t rows [9] = '{
    '{1'b0, 7'h5b, 4'h2, 4'hf},
    '{1'b0, 7'h3b, 4'h1, 4'hf},
    '{1'b1, 7'h3f, 4'h0, 4'hf},
    '{1'b1, 7'h3b, 4'h9, 4'hf},
    '{1'b1, 7'h5b, 4'ha, 4'hf},
    '{1'b1, 7'h5f, 4'h8, 4'hf},
    '{1'b1, 7'h11, 4'hc, 4'hf},
    '{1'b1, 7'h3b, 4'hd, 4'hf},
    '{1'b1, 7'h01, 4'h1, 4'hb}};
  always #5 ref_clk = ~ref_clk;
  gimh_ctrl_model #(.IFC_HOLD(`GIMH_IFC_MIN_CYC)) ctlr (.ref_clk(ref_clk), .ren_pin(ren_pin),
    .ifc_pin(ifc_pin), .cmd_valid(cmd_valid), .atn(atn), .cmd_byte(cmd_byte));
  gimh_handler #(.IFC_MIN_CYC(`GIMH_IFC_MIN_CYC)) DUT (.ref_clk(ref_clk), .reset(reset),
    .ren_pin(ren_pin), .ifc_pin(ifc_pin), .cmd_valid(cmd_valid), .atn(atn),
    .cmd_byte(cmd_byte), .addr_set(addr_set), .addr_set_valid(addr_set_valid),
    .local_key(local_key),
    .bus_trig_src(bus_trig_src), .lang_sel_valid(lang_sel_valid), .lang_sel(lang_sel),
    .state_q(state_q), .ctrl_q(ctrl_q), .lang_q(lang_q), .addr_q(addr_q));
  // Pulse counting and hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (ctrl_q.clear_pulse === 1'b1) n_clr++;
    if (ctrl_q.lang_reset === 1'b1) n_lrst++;
    if (ctrl_q.trig_pulse === 1'b1) layers |= ctrl_q.trig_layer;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One-cycle strobe on the local key or the language select
  task automatic strobe(input bit key, input gimh_pkg::gimh_lang_t l);
    @(negedge ref_clk);
    local_key = key;
    lang_sel_valid = !key;
    lang_sel = l;
    @(negedge ref_clk);
    local_key = 1'b0;
    lang_sel_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    chk({4'h0, state_q}, 8'h00);
    chk({6'h0, ctrl_q.panel_enable, ctrl_q.local_key_enable}, 8'h03);
    chk({3'h0, addr_q}, 8'h1b);
    $display("reset test done");
    foreach (rows[i]) begin
      if (ren_pin !== rows[i].ren) ctlr.set_ren(rows[i].ren);
      ctlr.send(rows[i].b);
      chk({4'h0, state_q & rows[i].mask}, {4'h0, rows[i].exp});
    end
    $display("table test done");
    ctlr.send(7'h3b);
    chk({5'h0, state_q.remote, ctrl_q.panel_enable, ctrl_q.local_key_enable}, 8'h05);
    strobe(1'b1, gimh_pkg::gimh_lang_std_t_val);
    chk({7'h0, state_q.remote}, 8'h00);
    ctlr.send(7'h3b);
    ctlr.send(7'h11);
    strobe(1'b1, gimh_pkg::gimh_lang_std_t_val);
    chk({6'h0, state_q.remote, ctrl_q.local_key_enable}, 8'h02);
    ctlr.send(7'h01);
    chk({6'h0, state_q.remote, ctrl_q.panel_enable}, 8'h01);
    $display("panel test done");
    ctlr.send(7'h3f);
    ctlr.send(7'h04);
    chk(8'(n_clr), 8'h00);
    ctlr.send(7'h14);
    chk(8'(n_clr), 8'h01);
    ctlr.send(7'h3b);
    ctlr.send(7'h04);
    chk(8'(n_clr), 8'h02);
    chk({3'h0, addr_q}, 8'h1b);
    bus_trig_src = 3'h5;
    ctlr.send(7'h5f);
    ctlr.send(7'h3f);
    ctlr.send(7'h3b);
    ctlr.send(7'h08);
    chk({5'h0, layers}, 8'h05);
    bus_trig_src = 3'h0;
    layers = 3'h0;
    ctlr.send(7'h08);
    chk({5'h0, layers}, 8'h00);
    $display("clear and trigger test done");
    strobe(1'b0, gimh_pkg::gimh_lang_std_t_val);
    chk(8'(n_lrst), 8'h00);
    strobe(1'b0, gimh_pkg::gimh_lang_legacy_t_val);
    chk(8'(n_lrst), 8'h01);
    chk({7'h0, lang_q}, 8'h01);
    ctlr.send(7'h3b);
    ctlr.send(7'h5b);
    chk({4'h0, state_q}, 8'h0a);
    ctlr.clear_bus();
    chk({4'h0, state_q}, 8'h00);
    chk({2'h0, lang_q, addr_q}, 8'h3b);
    $display("language and interface clear test done");
    @(negedge ref_clk);
    addr_set = 5'h05;
    addr_set_valid = 1'b1;
    @(negedge ref_clk);
    addr_set_valid = 1'b0;
    chk({3'h0, addr_q}, 8'h05);
    ctlr.send(7'h3b);
    chk({7'h0, state_q.listener}, 8'h00);
    ctlr.send(7'h25);
    chk({4'h0, state_q}, 8'h09);
    $display("address test done");
    @(negedge ref_clk);
    reset = 1'b1;
    @(negedge ref_clk);
    chk({3'h0, state_q, lang_q}, 8'h00);
    chk({3'h0, addr_q}, 8'h1b);
    reset = 1'b0;
    $display("second reset test done");
    final_report();
  end
endmodule
